// *** bench/status_sampler.sv ***
`timescale 1ns/1ps
// back-end logic: drives the pin as an input while released, counts driven rises
module status_sampler (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // pin
    input  wire logic pin_level,
    input  wire logic dev_oe,
    output logic      drive_val_q,
    output int        rise_cnt
);
    logic last_q;
    // toggles every cycle so a stale value never passes for a match
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            drive_val_q <= 1'b0;
            last_q      <= 1'b0;
            rise_cnt    <= 0;
        end
        else
        begin
            drive_val_q <= ~drive_val_q;
            last_q      <= pin_level & dev_oe;
            if (dev_oe && pin_level && !last_q)
                rise_cnt <= rise_cnt + 1;
        end
    end
endmodule

// *** bench/test_status_pin1_source_select.sv ***
`timescale 1ns/1ps
module test_status_pin1_source_select
    import pin1_pkg::*;
;
    localparam int LEN = 16;
    logic ref_clk, nrst, oe, out_q, alt_q, drv, pin_level;
    reg_req_t req;
    logic [7:0] rdata;
    video_status_t vid;
    int fails = 0, n_checks = 0, rises, hi, seed, n_rise;
    int codes[$] = '{1, 2, 3, 4, 5, 6, 10, 11, 12, 14};
    logic [7:0] r11, r10;
    logic expv, got;
    assign pin_level = oe ? out_q : drv;
    status_pin1_source_select #(.REF_LEN(LEN)) i_status_pin1_source_select (
        .ref_clk(ref_clk), .nrst(nrst), .req(req), .rdata_q(rdata), .vid(vid),
        .pin1_in(pin_level), .status_output_1_q(out_q), .status_output_1_oe_q(oe),
        .alt_input_function_q(alt_q));
    status_sampler i_status_sampler (
        .ref_clk(ref_clk), .nrst(nrst), .pin_level(pin_level), .dev_oe(oe),
        .drive_val_q(drv), .rise_cnt(rises));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (exp !== got)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // one line start, then count driven-high cycles and rises on the pin
    task automatic count_line(output int n_hi, output int n_up);
        int r0;
        r0 = rises;
        n_hi = 0;
        @(posedge ref_clk);
        vid.line_start <= 1'b1;
        @(posedge ref_clk);
        vid.line_start <= 1'b0;
        repeat (40)
        begin
            settle(1);
            if (out_q === 1'b1 && oe === 1'b1)
                n_hi++;
        end
        n_up = rises - r0;
    endtask
    // reference model of the level sources
    function automatic logic model(int code, video_status_t v, logic [7:0] c11, logic [7:0] c10);
        case (code)
            1: return v.adc_lsb;
            2: return c11[SWITCH1_BIT];
            3: return c11[LOCK_SPEED_BIT] ? v.hlock_fast : v.hlock_std;
            4: return v.vlock & v.hlock_std;
            5: return v.vlock & v.hlock_std & v.colour_det;
            6: return v.colour_sequence_line_flag;
            10: return v.odd_field;
            11: return v.vertical_sync_out;
            14: return c10[REF_LEN_BIT] ? v.vref_long : v.vref_short;
            default: return v.vertical_pulse_out;
        endcase
    endfunction
    initial
    begin
        nrst = 1'b0;
        req = '0;
        vid = '0;
        seed = $urandom(32'hB6FB079B);
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        settle(1);
        chk("oe_reset", 16'h0000, {15'h0, oe});
        rd(ADDR_PIN_SEL, 8'h00);
        rd(8'h3C, 8'h00);
        wr(ADDR_PIN_SEL, 8'hA5);
        rd(ADDR_PIN_SEL, 8'hA5);
        $display("test registers done");
        foreach (codes[i])
            repeat (4)
            begin
                r11 = 8'($urandom) & 8'h92;
                wr(ADDR_CTRL_11, r11);
                r10 = 8'($urandom) & 8'h08;
                wr(ADDR_CTRL_10, r10);
                wr(ADDR_PIN_SEL, {4'(codes[i]), 4'($urandom)});
                vid <= video_status_t'(24'($urandom));
                @(posedge ref_clk);
                vid.line_start <= 1'b0;
                if (codes[i] == 4 || codes[i] == 5)
                    vid.hlock_fast <= vid.hlock_std;
                settle(3);
                expv = model(codes[i], vid, r11, r10);
                got = out_q & oe;
                if (codes[i] == 1 && !r11[BYPASS_BIT])
                    chk("oe_reserved", 16'h0000, {15'h0, oe});
                else if (codes[i] < 10)
                    chk("pin", 16'(expv), 16'(got));
                else
                    chk("pin", 16'(expv), 16'(got));
            end
        $display("test level sources done");
        wr(ADDR_PIN_SEL, 8'h00);
        settle(3);
        chk("oe_input", 16'h0000, {15'h0, oe});
        chk("alt_input", {15'h0, ~drv}, {15'h0, alt_q});
        $display("test input function done");
        vid <= '0;
        wr(ADDR_PIN_SEL, 8'h70);
        settle(LEN + 4);
        count_line(hi, n_rise);
        chk("ref_len", 16'(LEN), 16'(hi));
        chk("ref_rise", 16'h0001, 16'(n_rise));
        $display("test horizontal reference done");
        wr(ADDR_SYNC_BEGIN, 8'h01);
        wr(ADDR_SYNC_STOP, 8'h02);
        wr(ADDR_PIN_SEL, 8'h80);
        settle(LEN + 4);
        count_line(hi, n_rise);
        chk("sync_len", 16'((2 - 1) * STEP8), 16'(hi));
        chk("sync_rise", 16'h0001, 16'(n_rise));
        $display("test horizontal sync done");
        wr(ADDR_GATE_START, 8'h05);
        wr(ADDR_GATE_MSB, 8'h00);
        wr(ADDR_PIN_SEL, 8'hF0);
        for (int f = 0; f < 4; f++)
        begin
            wr(ADDR_CTRL_13, 8'(f[1]) << FIELD_POL_BIT);
            vid.line_num <= 9'h005;
            vid.odd_field <= f[0];
            vid.line_start <= 1'b1;
            @(posedge ref_clk);
            vid.line_start <= 1'b0;
            settle(4);
            chk("field_id", {15'h0, f[0] ^ f[1]}, {15'h0, out_q});
        end
        $display("test field id done");
        wr(ADDR_GATE_STOP, 8'h07);
        wr(ADDR_PIN_SEL, 8'hD0);
        for (int g = 0; g < 2; g++)
        begin
            @(posedge ref_clk);
            vid.line_num <= (g != 0) ? 9'h007 : 9'h005;
            vid.line_start <= 1'b1;
            @(posedge ref_clk);
            vid.line_start <= 1'b0;
            settle(4);
            chk("window_gate", {15'h0, g == 0}, {15'h0, out_q});
        end
        $display("test vertical gate done");
        give_verdict();
    end
    initial
    begin
        #500000;
        fails++;
        give_verdict();
    end
endmodule

// *** inc/pin1_pkg.sv ***
package pin1_pkg;

    // register map (byte offsets on the plain register port)
    localparam logic [7:0] ADDR_PIN_SEL    = 8'h12;
    localparam logic [7:0] ADDR_CTRL_11    = 8'h11;
    localparam logic [7:0] ADDR_CTRL_10    = 8'h10;
    localparam logic [7:0] ADDR_CTRL_13    = 8'h13;
    localparam logic [7:0] ADDR_SYNC_BEGIN = 8'h06;
    localparam logic [7:0] ADDR_SYNC_STOP  = 8'h07;
    localparam logic [7:0] ADDR_GATE_START = 8'h15;
    localparam logic [7:0] ADDR_GATE_STOP  = 8'h16;
    localparam logic [7:0] ADDR_GATE_MSB   = 8'h17;
    localparam logic [7:0] ADDR_STATUS     = 8'h1F;

    // field positions
    localparam int SEL_LSB       = 4;
    localparam int BYPASS_BIT    = 1;
    localparam int LOCK_SPEED_BIT = 4;
    localparam int SWITCH1_BIT    = 7;
    localparam int REF_LEN_BIT    = 3;
    localparam int FINE_DELAY_LSB = 4;
    localparam int FIELD_POL_BIT  = 3;
    localparam int START_MSB_BIT = 0;
    localparam int STOP_MSB_BIT  = 1;

    localparam logic [7:0] REG_RESET = 8'h00;

    // horizontal reference length for standard data types
    localparam int LINE_REF_CYCLES  = 1440;
    localparam int LINE_REF_SAMPLES = 720;
    localparam int STEP8          = 8;
    localparam int STEP2          = 2;
    localparam logic [3:0] RAW_DATA_TYPE = 4'h7;

    typedef enum logic [3:0] {
        SRC_TRISTATE = 4'h0,
        SRC_ADC_LSB  = 4'h1,
        SRC_SWITCH   = 4'h2,
        SRC_HLOCK    = 4'h3,
        SRC_VHLOCK   = 4'h4,
        SRC_FULLLOCK = 4'h5,
        SRC_COLSEQ   = 4'h6,
        SRC_LINE_REF = 4'h7,
        SRC_HSYNC    = 4'h8,
        SRC_GATEDREF = 4'h9,
        SRC_ODD      = 4'hA,
        SRC_VSYNC    = 4'hB,
        SRC_VPULSE   = 4'hC,
        SRC_WINDOW   = 4'hD,
        SRC_VREF     = 4'hE,
        SRC_FIELD_ID = 4'hF
    } pin_src_t;

    // decoder state and timing arriving from the video core
    typedef struct packed {
        logic       adc_lsb;
        logic       hlock_std;
        logic       hlock_fast;
        logic       vlock;
        logic       colour_det;
        logic       colour_sequence_line_flag;
        logic       odd_field;
        logic       vertical_sync_out;
        logic       vertical_pulse_out;
        logic       vref_short;
        logic       vref_long;
        logic       line_start;
        logic [8:0] line_num;
        logic [3:0] data_type;
    } video_status_t;

    // register bus
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

endpackage

// *** verilog/status_pin1_source_select.sv ***
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
// What this block does
// - pin source picked by bits 7:4 of 12h
// - code 0000 floats pin, used as input
// - code 0001 drives converter LSBs in bypass
// - code 0011 horizontal lock, standard or fast
// - code 0100 vertical and horizontal lock
// - code 0101 both locks plus colour detected
// - code 0110 colour sequence line flag
// - code 0111 horizontal reference, valid data
// - standard types: reference high 1440 cycles
// - type 7: reference from 06h/07h, fine 10h
// - code 1000 horizontal sync, programmable width
// - code 1001 reference ANDed with vertical reference
// - code 1010 odd field high
// - code 1011 vertical sync
// - code 1100 vertical interval pulse
// - code 1101 vertical gate from 9-bit lines
// - code 1110 vertical reference, two lengths
// - code 1111 field id from start line
// - polarity bit inverts field id
module status_pin1_source_select
    import pin1_pkg::*;
#(
    parameter int REF_LEN = LINE_REF_CYCLES
)(
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          nrst,
    // register port
    input  wire reg_req_t      req,
    output logic [7:0]         rdata_q,
    // video core
    input  wire video_status_t vid,
    // status pin 1
    input  wire logic          pin1_in,
    output logic               status_output_1_q,
    output logic               status_output_1_oe_q,
    output logic               alt_input_function_q
);

    logic [7:0] sel_reg_q;
    logic [7:0] ctrl11_q;
    logic [7:0] ctrl10_q;
    logic [7:0] ctrl13_q;
    logic [7:0] sync_begin_q;
    logic [7:0] sync_stop_q;
    logic [7:0] gate_start_q;
    logic [7:0] gate_stop_q;
    logic [7:0] gate_msb_q;
    logic [8:0] gate_start_line;
    logic [8:0] gate_stop_line;
    pin_src_t   src;
    logic [1:0] horiz_fine_delay;
    logic [11:0] pos_cnt_q;
    logic        active_line_ref_q;
    logic        horiz_sync_out_q;
    logic        vertical_window_gate_q;
    logic        field_flip_q;
    logic [10:0] ref_stop;
    logic [10:0] sync_start;
    logic [10:0] sync_end;
    logic [10:0] raw_start;
    logic        pin_d;
    logic        oe_d;

    assign src              = pin_src_t'(sel_reg_q[SEL_LSB +: 4]);
    assign horiz_fine_delay = ctrl10_q[FINE_DELAY_LSB +: 2];
    assign gate_start_line  = {gate_msb_q[START_MSB_BIT], gate_start_q};
    assign gate_stop_line   = {gate_msb_q[STOP_MSB_BIT], gate_stop_q};

    // register writes
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            sel_reg_q    <= REG_RESET;
            ctrl11_q     <= REG_RESET;
            ctrl10_q     <= REG_RESET;
            ctrl13_q     <= REG_RESET;
            sync_begin_q <= REG_RESET;
            sync_stop_q  <= REG_RESET;
            gate_start_q <= REG_RESET;
            gate_stop_q  <= REG_RESET;
            gate_msb_q   <= REG_RESET;
        end
        else if (req.wr)
        begin
            case (req.addr)
                ADDR_PIN_SEL:    sel_reg_q    <= req.wdata;
                ADDR_CTRL_11:    ctrl11_q     <= req.wdata;
                ADDR_CTRL_10:    ctrl10_q     <= req.wdata;
                ADDR_CTRL_13:    ctrl13_q     <= req.wdata;
                ADDR_SYNC_BEGIN: sync_begin_q <= req.wdata;
                ADDR_SYNC_STOP:  sync_stop_q  <= req.wdata;
                ADDR_GATE_START: gate_start_q <= req.wdata;
                ADDR_GATE_STOP:  gate_stop_q  <= req.wdata;
                ADDR_GATE_MSB:   gate_msb_q   <= req.wdata;
                default:         ;
            endcase
        end
    end

    // register reads, data one cycle after the strobe
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            rdata_q <= REG_RESET;
        else if (req.rd)
        begin
            case (req.addr)
                ADDR_PIN_SEL:    rdata_q <= sel_reg_q;
                ADDR_CTRL_11:    rdata_q <= ctrl11_q;
                ADDR_CTRL_10:    rdata_q <= ctrl10_q;
                ADDR_CTRL_13:    rdata_q <= ctrl13_q;
                ADDR_SYNC_BEGIN: rdata_q <= sync_begin_q;
                ADDR_SYNC_STOP:  rdata_q <= sync_stop_q;
                ADDR_GATE_START: rdata_q <= gate_start_q;
                ADDR_GATE_STOP:  rdata_q <= gate_stop_q;
                ADDR_GATE_MSB:   rdata_q <= gate_msb_q;
                ADDR_STATUS:     rdata_q <= {5'h00, pin1_in, vertical_window_gate_q,
                                             active_line_ref_q};
                default:         rdata_q <= REG_RESET;
            endcase
        end
        else
            rdata_q <= REG_RESET;
    end

    // position counter within the line, in line-locked clock cycles
    always_ff @(posedge ref_clk)
    begin
        // parked at the end until the first line start, so no false reference after reset
        if (!nrst)
            pos_cnt_q <= 12'hFFF;
        else if (vid.line_start)
            pos_cnt_q <= 12'h000;
        else if (pos_cnt_q != 12'hFFF)
            pos_cnt_q <= pos_cnt_q + 12'h001;
    end

    // programmable edges: 8-cycle coarse steps, 2-cycle fine steps
    assign sync_start = 11'({sync_begin_q, 3'h0}) + 11'({horiz_fine_delay, 1'b0});
    assign sync_end   = 11'({sync_stop_q, 3'h0}) + 11'({horiz_fine_delay, 1'b0});
    assign raw_start  = sync_start;
    assign ref_stop   = 11'(REF_LEN);

    // horizontal reference
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            active_line_ref_q <= 1'b0;
        else if (vid.data_type == RAW_DATA_TYPE)
            active_line_ref_q <= ({1'b0, pos_cnt_q[10:0]} >= {1'b0, raw_start})
                                 && (pos_cnt_q[10:0] < sync_end) && !pos_cnt_q[11];
        else
            active_line_ref_q <= (pos_cnt_q < {1'b0, ref_stop});
    end

    // horizontal sync
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            horiz_sync_out_q <= 1'b0;
        else
            horiz_sync_out_q <= !pos_cnt_q[11] && (pos_cnt_q[10:0] >= sync_start)
                                && (pos_cnt_q[10:0] < sync_end);
    end

    // vertical gate and field identifier, updated at line starts
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            vertical_window_gate_q <= 1'b0;
            field_flip_q           <= 1'b0;
        end
        else if (vid.line_start)
        begin
            if (vid.line_num == gate_start_line)
            begin
                vertical_window_gate_q <= 1'b1;
                field_flip_q           <= vid.odd_field;
            end
            else if (vid.line_num == gate_stop_line)
                vertical_window_gate_q <= 1'b0;
        end
    end

    // source mux
    always_comb
    begin
        pin_d = 1'b0;
        oe_d  = 1'b1;
        case (src)
            SRC_TRISTATE: oe_d  = 1'b0;
            SRC_ADC_LSB:
            begin
                oe_d  = ctrl11_q[BYPASS_BIT];
                pin_d = ctrl11_q[BYPASS_BIT] & vid.adc_lsb;
            end
            SRC_SWITCH:   pin_d = ctrl11_q[SWITCH1_BIT];
            SRC_HLOCK:    pin_d = ctrl11_q[LOCK_SPEED_BIT] ? vid.hlock_fast : vid.hlock_std;
            SRC_VHLOCK:   pin_d = vid.vlock & vid.hlock_std;
            SRC_FULLLOCK: pin_d = vid.vlock & vid.hlock_std & vid.colour_det;
            SRC_COLSEQ:   pin_d = vid.colour_sequence_line_flag;
            SRC_LINE_REF: pin_d = active_line_ref_q;
            SRC_HSYNC:    pin_d = horiz_sync_out_q;
            SRC_GATEDREF: pin_d = active_line_ref_q &
                                  (ctrl10_q[REF_LEN_BIT] ? vid.vref_long : vid.vref_short);
            SRC_ODD:      pin_d = vid.odd_field;
            SRC_VSYNC:    pin_d = vid.vertical_sync_out;
            SRC_VPULSE:   pin_d = vid.vertical_pulse_out;
            SRC_WINDOW:   pin_d = vertical_window_gate_q;
            SRC_VREF:     pin_d = ctrl10_q[REF_LEN_BIT] ? vid.vref_long : vid.vref_short;
            SRC_FIELD_ID: pin_d = field_flip_q ^ ctrl13_q[FIELD_POL_BIT];
            default:      oe_d  = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            status_output_1_q    <= 1'b0;
            status_output_1_oe_q <= 1'b0;
            alt_input_function_q <= 1'b0;
        end
        else
        begin
            status_output_1_q    <= pin_d;
            status_output_1_oe_q <= oe_d;
            alt_input_function_q <= (src == SRC_TRISTATE) & pin1_in;
        end
    end

    pin_code_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_TRISTATE) |=> !status_output_1_oe_q)
        else $error("pin driven while code is zero");

    bypass_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_ADC_LSB && !ctrl11_q[BYPASS_BIT]) |=> !status_output_1_oe_q)
        else $error("lsb code drove pin without bypass");

    output_enable_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src != SRC_TRISTATE && src != SRC_ADC_LSB) |=> status_output_1_oe_q)
        else $error("pin not driven for an output code");

    alt_input_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_TRISTATE) |=> alt_input_function_q == $past(pin1_in))
        else $error("pin level not passed to input function");

    bypass_drive_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_ADC_LSB && ctrl11_q[BYPASS_BIT])
        |=> status_output_1_oe_q && status_output_1_q == $past(vid.adc_lsb))
        else $error("converter lsb not on pin in bypass");

    switch_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_SWITCH) |=> status_output_1_q == $past(ctrl11_q[SWITCH1_BIT]))
        else $error("switch level not on pin");

    lock_speed_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_HLOCK) |=> status_output_1_q == ($past(ctrl11_q[LOCK_SPEED_BIT]) ?
        $past(vid.hlock_fast) : $past(vid.hlock_std)))
        else $error("wrong horizontal lock form");

    lock_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_VHLOCK && !vid.vlock) |=> !status_output_1_q)
        else $error("lock flag high without vertical lock");

    full_lock_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_FULLLOCK && !vid.colour_det) |=> !status_output_1_q)
        else $error("full lock flag high without colour");

    colour_seq_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_COLSEQ) |=> status_output_1_q == $past(vid.colour_sequence_line_flag))
        else $error("colour sequence flag not on pin");

    line_ref_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_LINE_REF) |=> status_output_1_q == $past(active_line_ref_q))
        else $error("reference not on pin");

    sequence line_begin_s;
        vid.line_start && vid.data_type != RAW_DATA_TYPE;
    endsequence

    sequence ref_rise_s;
        ##2 active_line_ref_q;
    endsequence

    sequence gate_start_s;
        vid.line_start && vid.line_num == gate_start_line;
    endsequence

    ref_length_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (vid.data_type != RAW_DATA_TYPE && pos_cnt_q == 12'(REF_LEN)) |=> !active_line_ref_q)
        else $error("reference too long");

    ref_start_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        line_begin_s |-> ref_rise_s)
        else $error("reference not high at line start");

    raw_ref_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (vid.data_type == RAW_DATA_TYPE && !pos_cnt_q[11] && pos_cnt_q[10:0] < raw_start)
        |=> !active_line_ref_q)
        else $error("raw reference high before its begin");

    sync_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_HSYNC) |=> status_output_1_q == $past(horiz_sync_out_q))
        else $error("sync not on pin");

    sync_end_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (pos_cnt_q[11] || pos_cnt_q[10:0] >= sync_end) |=> !horiz_sync_out_q)
        else $error("sync high past its stop");

    gated_ref_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_GATEDREF && !active_line_ref_q) |=> !status_output_1_q)
        else $error("gated reference high outside reference");

    odd_field_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_ODD) |=> status_output_1_q == $past(vid.odd_field))
        else $error("odd field not on pin");

    vsync_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_VSYNC) |=> status_output_1_q == $past(vid.vertical_sync_out))
        else $error("vertical sync not on pin");

    vpulse_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_VPULSE) |=> status_output_1_q == $past(vid.vertical_pulse_out))
        else $error("vertical pulse not on pin");

    gate_open_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        gate_start_s |=> vertical_window_gate_q)
        else $error("gate not opened at start line");

    gate_close_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (vid.line_start && vid.line_num == gate_stop_line && vid.line_num != gate_start_line)
        |=> !vertical_window_gate_q)
        else $error("gate not closed at stop line");

    vref_select_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_VREF) |=> status_output_1_q == ($past(ctrl10_q[REF_LEN_BIT]) ?
        $past(vid.vref_long) : $past(vid.vref_short)))
        else $error("wrong vertical reference length");

    field_latch_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        gate_start_s |=> field_flip_q == $past(vid.odd_field))
        else $error("field id not taken at start line");

    fid_polarity_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (src == SRC_FIELD_ID)
        |=> status_output_1_q == ($past(field_flip_q) ^ $past(ctrl13_q[FIELD_POL_BIT])))
        else $error("field id polarity wrong");

    code_switch_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (req.wr && req.addr == ADDR_PIN_SEL && req.wdata[7:4] != 4'h0) ##1 1'b1
        |=> status_output_1_oe_q || $past(src) == SRC_ADC_LSB)
        else $error("new code not applied");

endmodule
